// ==== logic/wfs_core.sv ====
// wake-up evaluation, start identifier correlators and end of message detection
// assumes chips arrive as a one-cycle strobe from clock recovery on the same clock
`timescale 1ns/100ps
`default_nettype none
`include "wfs_consts.svh"

// Overview of operation
// - pattern mode wakes on 16-chip match; stops at window end or sync loss
// - equal-bits mode wakes when all bits in the window are equal
// - equal-bits mode aborts on a differing bit or sync loss
// - random-bits mode wakes if no code violation occurs in the window
// - random-bits mode aborts on code violation or sync loss
// - sync mode wakes as soon as sync arrives; 7.625-bit timeout and limit ignored
// - criterion select: 00 pattern, 01 random, 10 equal, 11 sync
// - wake pattern is high byte chips 15..8 over low byte chips 7..0
// - 7-bit limit; zero wakes at once in random/equal, never in pattern
// - framer searches after sync (slave) or wake-up (polling) until found or lost
// - two 16-chip correlators, each with own length and pattern bytes
// - 16-bit mode joins both as one 32-chip correlator; A length must be 16
// - 8-bit mode compares both in parallel; first match gives frame sync
// - gap mode: pattern A, then gap, then pattern B
// - extended mode inserts 0 for A match, 1 for B match
// - bits since frame sync counted to the length; counter cleared on frame sync
// - end of message on any enabled criterion: length, violation, sync loss
// - mode bit 7 selects gap resync; set resets the clock recovery pll
// - mode bits 6..3 hold wildcards for correlator A
// - mode bit 2 enables phase readjust on 1001 or 0110 chips
// - A length 0..16; zero A and B lengths give frame sync at sync, only in 16-bit mode
// - three equal chips are a violation; two equal chips a bit change
// - wake search starts only with sync inside four symbols; aborts on loss
// - window counter counts chips against the programmed limit
module wfs_core #(
  parameter logic [1:0] MODE_16BIT = 2'b00,
  parameter logic [1:0] MODE_8BIT  = 2'b01,
  parameter logic [1:0] MODE_GAP   = 2'b10,
  parameter logic [1:0] MODE_8EXT  = 2'b11
) (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic [7:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output logic      [7:0] rdata_out,
  input  wire logic       self_poll_in,
  input  wire logic       sym_sync_in,
  input  wire logic       chip_valid_in,
  input  wire logic       chip_in,
  output logic            wake_up_out,
  output logic            frame_sync_found_out,
  output logic            match_bit_valid_out,
  output logic            match_bit_out,
  output logic            end_message_detect_out,
  output logic            pll_reset_out,
  output logic            phase_adjust_out
);
  // 8-bit registers per config set, indexed by set, each decoded from its full offset
  logic [7:0] wake_ctrl_q [2];
  logic [7:0] wake_pat_lo_q [2];
  logic [7:0] wake_pat_hi_q [2];
  logic [7:0] wake_limit_q [2];
  logic [7:0] det_mode_q [2];
  logic [7:0] len_a_q [2];
  logic [7:0] len_b_q [2];
  logic [7:0] gap_q [2];
  logic [7:0] pta_lo_q [2];
  logic [7:0] pta_hi_q [2];
  logic [7:0] ptb_lo_q [2];
  logic [7:0] ptb_hi_q [2];
  logic [7:0] eom_ctrl_q [2];
  logic [7:0] msg_len_q [2];
  logic       cfg_sel_q;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      for (int i = 0; i < 2; i++) begin
        wake_ctrl_q[i]   <= `WFS_RESET_VAL;
        wake_pat_lo_q[i] <= `WFS_RESET_VAL;
        wake_pat_hi_q[i] <= `WFS_RESET_VAL;
        wake_limit_q[i]  <= `WFS_RESET_VAL;
        det_mode_q[i]    <= `WFS_RESET_VAL;
        len_a_q[i]       <= `WFS_RESET_VAL;
        len_b_q[i]       <= `WFS_RESET_VAL;
        gap_q[i]         <= `WFS_RESET_VAL;
        pta_lo_q[i]      <= `WFS_RESET_VAL;
        pta_hi_q[i]      <= `WFS_RESET_VAL;
        ptb_lo_q[i]      <= `WFS_RESET_VAL;
        ptb_hi_q[i]      <= `WFS_RESET_VAL;
        eom_ctrl_q[i]    <= `WFS_RESET_VAL;
        msg_len_q[i]     <= `WFS_RESET_VAL;
      end
      cfg_sel_q <= 1'b0;
    end else if (wr_in) begin
      unique case (addr_in)
        `WFS_OFF_WAKE_CTRL_A:   wake_ctrl_q[0]   <= wdata_in;
        `WFS_OFF_WAKE_PAT_LO_A: wake_pat_lo_q[0] <= wdata_in;
        `WFS_OFF_WAKE_PAT_HI_A: wake_pat_hi_q[0] <= wdata_in;
        `WFS_OFF_WAKE_LIMIT_A:  wake_limit_q[0]  <= wdata_in;
        `WFS_OFF_WAKE_CTRL_B:   wake_ctrl_q[1]   <= wdata_in;
        `WFS_OFF_WAKE_PAT_LO_B: wake_pat_lo_q[1] <= wdata_in;
        `WFS_OFF_WAKE_PAT_HI_B: wake_pat_hi_q[1] <= wdata_in;
        `WFS_OFF_WAKE_LIMIT_B:  wake_limit_q[1]  <= wdata_in;
        `WFS_OFF_DET_MODE_A:    det_mode_q[0]    <= wdata_in;
        `WFS_OFF_LEN_A_A:       len_a_q[0]       <= wdata_in;
        `WFS_OFF_LEN_B_A:       len_b_q[0]       <= wdata_in;
        `WFS_OFF_GAP_A:         gap_q[0]         <= wdata_in;
        `WFS_OFF_PTA_LO_A:      pta_lo_q[0]      <= wdata_in;
        `WFS_OFF_PTA_HI_A:      pta_hi_q[0]      <= wdata_in;
        `WFS_OFF_PTB_LO_A:      ptb_lo_q[0]      <= wdata_in;
        `WFS_OFF_PTB_HI_A:      ptb_hi_q[0]      <= wdata_in;
        `WFS_OFF_EOM_CTRL_A:    eom_ctrl_q[0]    <= wdata_in;
        `WFS_OFF_MSG_LEN_A:     msg_len_q[0]     <= wdata_in;
        `WFS_OFF_DET_MODE_B:    det_mode_q[1]    <= wdata_in;
        `WFS_OFF_LEN_A_B:       len_a_q[1]       <= wdata_in;
        `WFS_OFF_LEN_B_B:       len_b_q[1]       <= wdata_in;
        `WFS_OFF_GAP_B:         gap_q[1]         <= wdata_in;
        `WFS_OFF_PTA_LO_B:      pta_lo_q[1]      <= wdata_in;
        `WFS_OFF_PTA_HI_B:      pta_hi_q[1]      <= wdata_in;
        `WFS_OFF_PTB_LO_B:      ptb_lo_q[1]      <= wdata_in;
        `WFS_OFF_PTB_HI_B:      ptb_hi_q[1]      <= wdata_in;
        `WFS_OFF_EOM_CTRL_B:    eom_ctrl_q[1]    <= wdata_in;
        `WFS_OFF_MSG_LEN_B:     msg_len_q[1]     <= wdata_in;
        `WFS_OFF_CFG_SEL:       cfg_sel_q        <= wdata_in[0];
        default: ;
      endcase
    end
  end

  // active set only drives behaviour
  logic                   s;
  logic [1:0]             wake_crit;
  logic [15:0]            wake_pat;
  logic [6:0]             wake_limit;
  logic [1:0]             tsi_mode;
  logic [3:0]             wca;
  logic [4:0]             len_a;
  logic [4:0]             len_b;
  logic [31:0]            corr_pat;
  logic [4:0]             gap_half_bits;
  assign s             = cfg_sel_q;
  assign wake_crit     = wake_ctrl_q[s][1:0];
  assign wake_pat      = {wake_pat_hi_q[s], wake_pat_lo_q[s]};
  assign wake_limit    = wake_limit_q[s][6:0];
  assign tsi_mode      = det_mode_q[s][1:0];
  assign wca           = det_mode_q[s][`WFS_WCA_HI:`WFS_WCA_LO];
  assign len_a         = len_a_q[s][4:0];
  assign len_b         = len_b_q[s][4:0];
  assign corr_pat      = {ptb_hi_q[s], ptb_lo_q[s], pta_hi_q[s], pta_lo_q[s]};
  assign gap_half_bits = gap_q[s][7:3];

  // masked compare of the newest len chips of history against pattern
  function automatic logic corr_hit(input logic [15:0] hist, input logic [15:0] pat,
                                    input logic [4:0] len, input logic [15:0] wild);
    logic [15:0] m;
    m = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      if (5'(i) < len) begin
        m[i] = 1'b1;
      end
    end
    corr_hit = (len != 5'h00) && (len <= `WFS_MAX_CORR_LEN) &&
               ((((hist ^ pat) & m) & ~wild) == 16'h0000);
  endfunction

  wfs_pkg::wfs_state_t state_q;
  logic [31:0] hist_q;
  logic [1:0]  last2_q;
  logic [1:0]  eq_run_q;
  logic [6:0]  win_cnt_q;
  logic [4:0]  fill_q;
  logic [7:0]  tmr_q;
  logic [8:0]  bit_cnt_q;
  logic        chip_phase_q;
  logic        first_bit_q;
  logic        cur_bit_q;
  logic        sync_q;

  logic        cv;
  logic        bit_stb;
  logic        new_bit;
  logic [31:0] hist_n;
  logic        hit_a;
  logic        hit_b;
  logic        hit_32;
  logic        sync_lost;
  assign sync_lost = sync_q && !sym_sync_in;
  assign hist_n    = {hist_q[30:0], chip_in};
  // third equal chip in a row
  assign cv        = chip_valid_in && (eq_run_q == 2'd2) && (last2_q[0] == chip_in);
  assign bit_stb   = chip_valid_in && chip_phase_q;
  assign new_bit   = last2_q[0];
  assign hit_a     = corr_hit(hist_n[15:0], corr_pat[15:0], len_a, {12'h000, wca});
  assign hit_b     = corr_hit(hist_n[15:0], corr_pat[31:16], len_b, 16'h0000);
  // B holds the newest chips, A the chips before them
  assign hit_32    = (len_b == 5'h00) ? hit_a :
                     (corr_hit(hist_n[15:0], corr_pat[31:16], len_b, 16'h0000) &&
                      corr_hit(hist_n[5'(len_b) +: 16], corr_pat[15:0], len_a,
                               {12'h000, wca}));

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sync_q   <= 1'b0;
      hist_q   <= 32'h0000_0000;
      last2_q  <= 2'b00;
      eq_run_q <= 2'd0;
    end else begin
      sync_q <= sym_sync_in;
      if (chip_valid_in) begin
        hist_q   <= hist_n;
        last2_q  <= {last2_q[0], chip_in};
        eq_run_q <= (chip_in == last2_q[0]) ? ((eq_run_q == 2'd2) ? 2'd2 : eq_run_q + 2'd1)
                                             : 2'd1;
      end
    end
  end

  // bit boundary tracking; readjust on 1001/0110 when enabled
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      chip_phase_q <= 1'b0;
      cur_bit_q    <= 1'b0;
    end else if (!sym_sync_in) begin
      chip_phase_q <= 1'b0;
    end else if (chip_valid_in) begin
      if (det_mode_q[s][`WFS_BIT_PHASE_ADJ] &&
          (hist_n[3:0] == 4'b1001 || hist_n[3:0] == 4'b0110)) begin
        chip_phase_q <= 1'b0;
      end else begin
        chip_phase_q <= !chip_phase_q;
      end
      if (chip_phase_q) begin
        cur_bit_q <= new_bit;
      end
    end
  end
  assign phase_adjust_out = chip_valid_in && det_mode_q[s][`WFS_BIT_PHASE_ADJ] &&
                            (hist_n[3:0] == 4'b1001 || hist_n[3:0] == 4'b0110);

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_q                <= wfs_pkg::WFS_IDLE;
      win_cnt_q              <= 7'h00;
      fill_q                 <= 5'h00;
      tmr_q                  <= 8'h00;
      bit_cnt_q              <= 9'h000;
      first_bit_q            <= 1'b0;
      wake_up_out            <= 1'b0;
      frame_sync_found_out   <= 1'b0;
      match_bit_valid_out    <= 1'b0;
      match_bit_out          <= 1'b0;
      end_message_detect_out <= 1'b0;
      pll_reset_out          <= 1'b0;
    end else begin
      wake_up_out            <= 1'b0;
      frame_sync_found_out   <= 1'b0;
      match_bit_valid_out    <= 1'b0;
      end_message_detect_out <= 1'b0;
      pll_reset_out          <= 1'b0;
      unique case (state_q)
        wfs_pkg::WFS_IDLE: begin
          win_cnt_q   <= 7'h00;
          fill_q      <= 5'h00;
          first_bit_q <= 1'b1;
          if (!self_poll_in) begin
            tmr_q <= 8'h00;
            if (sym_sync_in) begin
              state_q <= wfs_pkg::WFS_SEARCH;
            end
          end else if (sym_sync_in) begin
            tmr_q <= 8'h00;
            if (wake_crit == wfs_pkg::WFS_WAKE_SYNC) begin
              wake_up_out <= 1'b1;
              state_q     <= wfs_pkg::WFS_SEARCH;
            end else if (wake_crit != wfs_pkg::WFS_WAKE_PATTERN && wake_limit == 7'h00) begin
              wake_up_out <= 1'b1;
              state_q     <= wfs_pkg::WFS_SEARCH;
            end else if (tmr_q <= 8'(`WFS_RUNIN_CHIPS)) begin
              state_q <= wfs_pkg::WFS_WAKE;
            end
          end else if (chip_valid_in) begin
            // sync timeout wraps the run-in count; only non-sync criteria check it, sync wake ignores it
            tmr_q <= (tmr_q == 8'(`WFS_SYNC_TIMEOUT_CHIPS)) ? 8'h00 : tmr_q + 8'h01;
          end
        end
        wfs_pkg::WFS_WAKE: begin
          if (!sym_sync_in) begin
            state_q <= wfs_pkg::WFS_IDLE;
          end else if (chip_valid_in) begin
            win_cnt_q <= win_cnt_q + 7'h01;
            fill_q    <= (fill_q == 5'h10) ? fill_q : fill_q + 5'h01;
            unique case (wake_crit)
              wfs_pkg::WFS_WAKE_PATTERN: begin
                if (fill_q >= 5'h0f && hist_n[15:0] == wake_pat) begin
                  wake_up_out <= 1'b1;
                  state_q     <= wfs_pkg::WFS_SEARCH;
                end else if (win_cnt_q + 7'h01 >= wake_limit) begin
                  state_q <= wfs_pkg::WFS_IDLE;
                end
              end
              wfs_pkg::WFS_WAKE_RANDOM: begin
                if (cv) begin
                  state_q <= wfs_pkg::WFS_IDLE;
                end else if (win_cnt_q + 7'h01 >= wake_limit) begin
                  wake_up_out <= 1'b1;
                  state_q     <= wfs_pkg::WFS_SEARCH;
                end
              end
              default: begin
                if (bit_stb && !first_bit_q && new_bit != cur_bit_q) begin
                  state_q <= wfs_pkg::WFS_IDLE;
                end else if (win_cnt_q + 7'h01 >= wake_limit) begin
                  wake_up_out <= 1'b1;
                  state_q     <= wfs_pkg::WFS_SEARCH;
                end
                if (bit_stb) begin
                  first_bit_q <= 1'b0;
                end
              end
            endcase
          end
        end
        wfs_pkg::WFS_SEARCH: begin
          bit_cnt_q <= 9'h000;
          if (!sym_sync_in) begin
            state_q <= wfs_pkg::WFS_IDLE;
          end else if (tsi_mode == MODE_16BIT && len_a == 5'h00 && len_b == 5'h00) begin
            frame_sync_found_out <= 1'b1;
            state_q              <= wfs_pkg::WFS_FRAME;
          end else if (chip_valid_in) begin
            if (tsi_mode == MODE_16BIT) begin
              if (hit_32) begin
                frame_sync_found_out <= 1'b1;
                state_q              <= wfs_pkg::WFS_FRAME;
              end
            end else if (tsi_mode == MODE_GAP) begin
              if (hit_a) begin
                tmr_q   <= 8'h00;
                state_q <= wfs_pkg::WFS_GAP;
              end
            end else if (hit_a || hit_b) begin
              frame_sync_found_out <= 1'b1;
              state_q              <= wfs_pkg::WFS_FRAME;
              if (tsi_mode == MODE_8EXT) begin
                match_bit_valid_out <= 1'b1;
                match_bit_out       <= !hit_a;
              end
            end
          end
        end
        wfs_pkg::WFS_GAP: begin
          // gap counted in chips (half bits); pattern B must follow within its length plus 11 chips after the gap
          if (chip_valid_in) begin
            tmr_q <= tmr_q + 8'h01;
            if (tmr_q == {3'b000, gap_half_bits}) begin
              pll_reset_out <= det_mode_q[s][`WFS_BIT_GAP_RESYNC];
            end
            if (tmr_q > {3'b000, gap_half_bits} && hit_b) begin
              frame_sync_found_out <= 1'b1;
              state_q              <= wfs_pkg::WFS_FRAME;
            end else if (tmr_q > {3'b000, gap_half_bits} + {3'b000, len_b} + 8'd11) begin
              state_q <= wfs_pkg::WFS_SEARCH;
            end
          end
        end
        wfs_pkg::WFS_FRAME: begin
          if (bit_stb) begin
            bit_cnt_q <= bit_cnt_q + 9'h001;
          end
          if ((eom_ctrl_q[s][0] && bit_stb && bit_cnt_q == {1'b0, msg_len_q[s]}) ||
              (eom_ctrl_q[s][1] && cv) || (eom_ctrl_q[s][2] && !sym_sync_in)) begin
            end_message_detect_out <= 1'b1;
            state_q                <= wfs_pkg::WFS_IDLE;
          end else if (!sym_sync_in) begin
            state_q <= wfs_pkg::WFS_IDLE;
          end
        end
        default: state_q <= wfs_pkg::WFS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rdata_out <= 8'h00;
    end else if (rd_in && addr_in == `WFS_OFF_STATUS) begin
      rdata_out <= {5'h00, 3'(state_q)};
    end else if (rd_in && addr_in == `WFS_OFF_CFG_SEL) begin
      rdata_out <= {7'h00, cfg_sel_q};
    end else begin
      rdata_out <= 8'h00;
    end
  end

  a_eom_needs_frame: assert property (@(posedge clk_in) disable iff (rst_in)
    end_message_detect_out |-> $past(state_q) == wfs_pkg::WFS_FRAME)
    else $error("end of message outside a frame");
  a_wake_from_wait: assert property (@(posedge clk_in) disable iff (rst_in)
    wake_up_out |-> ($past(state_q) inside {wfs_pkg::WFS_WAKE, wfs_pkg::WFS_IDLE}))
    else $error("wake-up from wrong state");
  a_wake_sync_loss: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_q == wfs_pkg::WFS_WAKE && !sym_sync_in) |=> state_q == wfs_pkg::WFS_IDLE)
    else $error("wake search kept after sync loss");
  a_random_cv_abort: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_q == wfs_pkg::WFS_WAKE && wake_crit == 2'b01 && cv) |=> !wake_up_out)
    else $error("random wake despite violation");
  a_pattern_zero: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_q == wfs_pkg::WFS_IDLE && self_poll_in && wake_crit == 2'b00 && wake_limit == 7'h00)
    |=> !wake_up_out)
    else $error("pattern wake with zero limit");
  a_frame_sync_found_goes_frame: assert property (@(posedge clk_in) disable iff (rst_in)
    frame_sync_found_out |-> state_q == wfs_pkg::WFS_FRAME)
    else $error("frame sync without frame");
  a_ext_bit_pair: assert property (@(posedge clk_in) disable iff (rst_in)
    match_bit_valid_out |-> frame_sync_found_out)
    else $error("match bit without frame sync");
  a_count_cleared: assert property (@(posedge clk_in) disable iff (rst_in)
    frame_sync_found_out |-> bit_cnt_q == 9'h000)
    else $error("bit counter not cleared at frame sync");
  c_wake: cover property (@(posedge clk_in) disable iff (rst_in) wake_up_out);
  c_frame_sync_found: cover property (@(posedge clk_in) disable iff (rst_in) frame_sync_found_out);
  c_eom: cover property (@(posedge clk_in) disable iff (rst_in) end_message_detect_out);
endmodule
`default_nettype wire

// ==== logic/wfs_consts.svh ====
// constants for the wake-up and frame sync block: offsets, fields, reset values, timing
// assumes inclusion by the package and the design file only
`ifndef WFS_CONSTS_SVH
`define WFS_CONSTS_SVH
`define WFS_OFF_WAKE_CTRL_A    8'h25
`define WFS_OFF_WAKE_PAT_LO_A  8'h26
`define WFS_OFF_WAKE_PAT_HI_A  8'h27
`define WFS_OFF_WAKE_LIMIT_A   8'h28
`define WFS_OFF_WAKE_CTRL_B    8'h46
`define WFS_OFF_WAKE_PAT_LO_B  8'h47
`define WFS_OFF_WAKE_PAT_HI_B  8'h48
`define WFS_OFF_WAKE_LIMIT_B   8'h49
`define WFS_OFF_DET_MODE_A     8'h82
`define WFS_OFF_LEN_A_A        8'h83
`define WFS_OFF_LEN_B_A        8'h84
`define WFS_OFF_PTA_LO_A       8'h86
`define WFS_OFF_PTA_HI_A       8'h87
`define WFS_OFF_PTB_LO_A       8'h88
`define WFS_OFF_PTB_HI_A       8'h89
`define WFS_OFF_EOM_CTRL_A     8'h8a
`define WFS_OFF_MSG_LEN_A      8'h8b
`define WFS_OFF_GAP_A          8'h85
`define WFS_OFF_DET_MODE_B     8'ha2
`define WFS_OFF_LEN_A_B        8'ha3
`define WFS_OFF_LEN_B_B        8'ha4
`define WFS_OFF_GAP_B          8'ha5
`define WFS_OFF_PTA_LO_B       8'ha6
`define WFS_OFF_PTA_HI_B       8'ha7
`define WFS_OFF_PTB_LO_B       8'ha8
`define WFS_OFF_PTB_HI_B       8'ha9
`define WFS_OFF_EOM_CTRL_B     8'haa
`define WFS_OFF_MSG_LEN_B      8'hab
`define WFS_OFF_STATUS         8'hf0
`define WFS_OFF_CFG_SEL        8'hf1
`define WFS_RESET_VAL          8'h00
`define WFS_BIT_GAP_RESYNC     7
`define WFS_WCA_HI             6
`define WFS_WCA_LO             3
`define WFS_BIT_PHASE_ADJ      2
`define WFS_MAX_CORR_LEN       5'h10
`define WFS_MIN_PAT_LIMIT      7'h11
`define WFS_SYNC_TIMEOUT_MCHIP 7625
`define WFS_SYNC_TIMEOUT_CHIPS ((`WFS_SYNC_TIMEOUT_MCHIP * 2) / 1000)
`define WFS_RUNIN_CHIPS        8
`endif

// ==== logic/wfs_pkg.sv ====
// types for the wake-up and frame sync block
// assumes the constants header sits beside it
`include "wfs_consts.svh"
package wfs_pkg;
  typedef enum logic [1:0] {
    WFS_WAKE_PATTERN = 2'b00,
    WFS_WAKE_RANDOM  = 2'b01,
    WFS_WAKE_EQUAL   = 2'b10,
    WFS_WAKE_SYNC    = 2'b11
  } wfs_wake_crit_t;
  typedef enum logic [1:0] {
    WFS_TSI_16BIT,
    WFS_TSI_8BIT,
    WFS_TSI_GAP,
    WFS_TSI_8EXT
  } wfs_tsi_mode_t;
  typedef enum logic [2:0] {
    WFS_IDLE,
    WFS_WAKE,
    WFS_SEARCH,
    WFS_GAP,
    WFS_FRAME
  } wfs_state_t;
endpackage

// ==== verif/wfs_chip_src.sv ====
// clock recovery stand-in: symbol sync level and one-cycle chip strobes
// assumes the bench calls set_sync and send from its main sequence
`timescale 1ns/100ps
`default_nettype none
module wfs_chip_src (
  input  wire logic clk_in,
  output logic      sym_sync_out,
  output logic      chip_valid_out,
  output logic      chip_out
);
  initial begin
    sym_sync_out = 1'b0;
    chip_valid_out = 1'b0;
    chip_out = 1'b0;
  end
  task automatic set_sync(input logic v);
    @(posedge clk_in);
    sym_sync_out <= v;
  endtask
  // oldest chip first; line shows the inverse between strobes
  task automatic send(input logic [31:0] pat, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge clk_in);
      chip_valid_out <= 1'b1;
      chip_out <= pat[i];
      @(posedge clk_in);
      chip_valid_out <= 1'b0;
      chip_out <= ~pat[i];
      repeat (2) @(posedge clk_in);
    end
  endtask
endmodule
`default_nettype wire

// ==== verif/test_wakeup_and_frame_sync.sv ====
// self-checking bench for the wake-up and frame sync core
// assumes the clock recovery stand-in beside it
`timescale 1ns/100ps
`default_nettype none
module test_wakeup_and_frame_sync;
  logic       clk_in, rst_in, wr_in, rd_in, self_poll_in;
  logic [7:0] addr_in, wdata_in, rdata_out;
  logic       sync, cv, ch, wake, fs, mbv, mb, end_message_detect, pllr, padj;
  logic [7:0] n_wake = 8'h00;
  logic [7:0] n_fs = 8'h00;
  logic [7:0] n_eom = 8'h00;
  logic [7:0] n_mb0 = 8'h00;
  logic [7:0] n_mb1 = 8'h00;
  logic [7:0] n_padj = 8'h00;
  logic [7:0] n_pll = 8'h00;
  int         n_errors, checks;
  wfs_chip_src src (.clk_in(clk_in), .sym_sync_out(sync), .chip_valid_out(cv), .chip_out(ch));
  wfs_core dut (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .self_poll_in(self_poll_in),
    .sym_sync_in(sync), .chip_valid_in(cv), .chip_in(ch), .wake_up_out(wake),
    .frame_sync_found_out(fs), .match_bit_valid_out(mbv), .match_bit_out(mb),
    .end_message_detect_out(end_message_detect), .pll_reset_out(pllr), .phase_adjust_out(padj));
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  // event pulses stand one cycle, so count them at every edge
  always @(posedge clk_in) begin
    if (wake === 1'b1) n_wake <= n_wake + 8'h01;
    if (fs === 1'b1) n_fs <= n_fs + 8'h01;
    if (end_message_detect === 1'b1) n_eom <= n_eom + 8'h01;
    if (mbv === 1'b1 && mb === 1'b0) n_mb0 <= n_mb0 + 8'h01;
    if (mbv === 1'b1 && mb === 1'b1) n_mb1 <= n_mb1 + 8'h01;
    if (padj === 1'b1) n_padj <= n_padj + 8'h01;
    if (pllr === 1'b1) n_pll <= n_pll + 8'h01;
  end
  task automatic report_and_stop;
    if (n_errors == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 chk(rdata_out, e);
  endtask
  // sync drop ends the previous burst before a fresh one
  task automatic burst(input logic poll, input logic [31:0] pat, input int n);
    src.set_sync(1'b0);
    repeat (8) @(posedge clk_in);
    self_poll_in <= poll;
    src.set_sync(1'b1);
    src.send(pat, n);
    repeat (4) @(posedge clk_in);
  endtask
  task automatic wake_random;
    logic [7:0] b;
    wr(8'h25, 8'h01);
    wr(8'h28, 8'h00);
    b = n_wake;
    burst(1'b1, 32'h0000_00aa, 8);
    chk(n_wake - b, 8'h01);
    wr(8'h28, 8'h14);
    b = n_wake;
    burst(1'b1, 32'h0000_a7aa, 16);
    chk(n_wake - b, 8'h00);
    b = n_wake;
    burst(1'b1, 32'h9696_6a6a, 32);
    chk(n_wake - b, 8'h01);
  endtask
  task automatic wake_equal;
    logic [7:0] b;
    wr(8'h25, 8'h02);
    b = n_wake;
    burst(1'b1, 32'h9696_6a6a, 32);
    chk(n_wake - b, 8'h00);
    b = n_wake;
    burst(1'b1, 32'haaaa_aaaa, 32);
    chk(n_wake - b, 8'h01);
  endtask
  task automatic wake_pattern;
    logic [7:0] b;
    wr(8'h25, 8'h00);
    wr(8'h26, 8'h6a);
    wr(8'h27, 8'h96);
    wr(8'h28, 8'h30);
    b = n_wake;
    burst(1'b1, 32'haaaa_966a, 32);
    chk(n_wake - b, 8'h01);
    wr(8'h28, 8'h00);
    b = n_wake;
    burst(1'b1, 32'haaaa_966a, 32);
    chk(n_wake - b, 8'h00);
  endtask
  task automatic frame_sets;
    logic [7:0] f, m, a, b, p;
    wr(8'h82, 8'h01);
    wr(8'h83, 8'h08);
    wr(8'h84, 8'h08);
    wr(8'h86, 8'h96);
    wr(8'h88, 8'h33);
    wr(8'h8a, 8'h01);
    wr(8'h8b, 8'h03);
    f = n_fs;
    m = n_eom;
    burst(1'b0, 32'haaaa_96aa, 32);
    chk(n_fs - f, 8'h01);
    chk(n_eom - m, 8'h01);
    // extended mode, wildcards over the low nibble of A, phase readjust on
    wr(8'h82, 8'h7f);
    wr(8'h86, 8'h9f);
    a = n_mb0;
    b = n_mb1;
    p = n_padj;
    burst(1'b0, 32'haaaa_96aa, 32);
    chk(n_mb0 - a, 8'h01);
    chk(n_padj - p, 8'h02);
    burst(1'b0, 32'haaaa_33aa, 32);
    chk(n_mb1 - b, 8'h01);
    // gap mode: A, then an 8-chip gap with pll reset, then B
    wr(8'h82, 8'hfa);
    wr(8'h85, 8'h40);
    f = n_fs;
    p = n_pll;
    burst(1'b0, 32'h96aa_aa33, 32);
    chk(n_fs - f, 8'h01);
    chk(n_pll - p, 8'h01);
    // set B still holds reset values: 16-bit mode with zero length
    // sync dropped first so the switch cannot start a search on its own
    src.set_sync(1'b0);
    wr(8'hf1, 8'h01);
    f = n_fs;
    burst(1'b0, 32'h0000_000a, 4);
    chk(n_fs - f, 8'h01);
  endtask
  initial begin
    {rst_in, wr_in, rd_in, self_poll_in} = 4'b1000;
    addr_in = 8'h00;
    wdata_in = 8'h00;
    n_errors = 0;
    checks = 0;
    repeat (6) @(posedge clk_in);
    rst_in <= 1'b0;
    rd(8'hf0, 8'h00);
    wr(8'h25, 8'h03);
    rd(8'h25, 8'h00);
    rd(8'h10, 8'h00);
    wake_random();
    wake_equal();
    wake_pattern();
    frame_sets();
    report_and_stop();
  end
  initial begin
    #900000;
    n_errors++;
    report_and_stop();
  end
endmodule
`default_nettype wire
